/* shared/output_crossbar_pkg.sv */
`default_nettype none
package output_crossbar_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OUTPUT_ENABLE = 8'h09;
  localparam logic [7:0] ADDR_BANK1_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_SOURCE_SELECT_LO = 8'h44;
  localparam logic [7:0] ADDR_SOURCE_SELECT_MID = 8'h45;
  localparam logic [7:0] ADDR_SOURCE_SELECT_HI = 8'h46;
  localparam logic [7:0] ADDR_BANK2_CTRL = 8'h47;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ENABLE_BIT_C = 5;
  localparam int unsigned ENABLE_BIT_A = 4;
  localparam int unsigned ENABLE_BIT_B = 2;
  localparam int unsigned BANK_SOURCE_BIT = 7;
  localparam int unsigned SEL_A_MSB = 3;
  localparam int unsigned SEL_A_LSB = 1;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Crosspoint select codes
  typedef enum logic [2:0] {
    SRC_REFERENCE = 3'h0,
    SRC_BANK1_N = 3'h1,
    SRC_BANK1_HALF = 3'h2,
    SRC_BANK1_THIRD = 3'h3,
    SRC_BANK2_N = 3'h4,
    SRC_BANK2_HALF = 3'h5,
    SRC_BANK2_QUARTER = 3'h6,
    SRC_RESERVED = 3'h7
  } source_code_e;

  // ----------------------------------------------------------------
  // Reset values and fixed ratios
  // ----------------------------------------------------------------
  localparam logic RST_ENABLE = 1'b0;
  localparam source_code_e RST_SELECT = SRC_REFERENCE;
  localparam logic [6:0] RST_DIVISOR = 7'h08;
  localparam logic RST_BANK_SOURCE = 1'b0;
  localparam int unsigned BANK1_FIXED_RATIO = 3;
  localparam int unsigned BANK2_FIXED_RATIO = 4;
  // Serial slave address; value is arbitrary
  localparam logic [6:0] DEVICE_ADDRESS = 7'h2A;

endpackage : output_crossbar_pkg
`default_nettype wire

/* shared/reg_access_if.sv */
`default_nettype none
// Register access between the serial port and the register file
interface reg_access_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (output wr_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_access_if
`default_nettype wire

/* logic/divider_bank.sv */
`default_nettype none
module divider_bank
  import output_crossbar_pkg::*;
#(
  parameter int unsigned FIXED_RATIO = 3
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire logic [6:0] i_divisor,
  output logic o_div_n,
  output logic o_div_half,
  output logic o_div_fixed
);

  logic [6:0] count_reg;
  logic [1:0] mod3_reg;
  logic wrap;
  logic [6:0] count_next;
  logic [1:0] mod3_next;
  logic [6:0] divisor_seen_reg;
  logic restart;

  // ----------------------------------------------------------------
  // Shared phase counter
  // ----------------------------------------------------------------
  // Taps derive from one counter, the /3 tap from a mod-3 count cleared on its wrap, so a wrap is a common rising edge if each ratio divides the divisor
  always_comb
  begin
    restart = (i_divisor != divisor_seen_reg);
    wrap = (count_reg >= 7'(i_divisor - 7'h01));
    count_next = wrap ? 7'h00 : 7'(count_reg + 7'h01);
    mod3_next = (wrap || mod3_reg == 2'h2) ? 2'h0 : 2'(mod3_reg + 2'h1);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      count_reg <= 7'(RST_DIVISOR - 7'h01);
      mod3_reg <= 2'h0;
      divisor_seen_reg <= RST_DIVISOR;
    end
    else
    begin
      divisor_seen_reg <= i_divisor;
      // New divisor restarts the phase, so the next tick is a common wrap
      if (restart)
        count_reg <= 7'(i_divisor - 7'h01);
      else if (i_tick)
      begin
        count_reg <= count_next;
        mod3_reg <= mod3_next;
      end
    end
  end

  // Taps are high from each wrap, so edges coincide for proper divisors
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_div_n <= 1'b0;
      o_div_half <= 1'b0;
      o_div_fixed <= 1'b0;
    end
    else if (restart)
    begin
      // Taps parked low so no stray edge precedes the restart wrap
      o_div_n <= 1'b0;
      o_div_half <= 1'b0;
      o_div_fixed <= 1'b0;
    end
    else if (i_tick)
    begin
      o_div_n <= (count_next < (i_divisor >> 1));
      o_div_half <= ~count_next[0];
      o_div_fixed <= (FIXED_RATIO == 4) ? ~count_next[1] : (mod3_next == 2'h0);
    end
  end

endmodule : divider_bank
`default_nettype wire

/* logic/serial_config_port.sv */
`default_nettype none
module serial_config_port
  import output_crossbar_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  reg_access_if.port bus
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100
  } port_state_e;

  typedef enum logic [1:0] {
    PH_DEV = 2'b00,
    PH_REG = 2'b01,
    PH_DATA = 2'b10
  } byte_phase_e;

  port_state_e state_reg;
  byte_phase_e phase_reg;
  logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic read_mode_reg;
  logic [7:0] pointer_reg;
  logic wr_en_reg;
  logic [7:0] wdata_reg;
  logic scl_rise, scl_fall, start_seen, stop_seen, byte_done;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
    end
    else
    begin
      {scl_meta, scl_sync, scl_prev} <= {i_scl, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {i_sda, sda_meta, sda_sync};
    end
  end

  // Bus events from the synchronised levels
  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_seen = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign byte_done = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == 4'h8);

  // Open drain: only ever pulls low
  assign o_sda = 1'b0;
  assign o_sda_oe = (state_reg == ST_ACK) || (state_reg == ST_TX && !shift_reg[7]);

  // ----------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_DEV;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'hFF;
      read_mode_reg <= 1'b0;
    end
    else if (start_seen)
    begin
      state_reg <= ST_RX;
      phase_reg <= PH_DEV;
      bit_cnt_reg <= 4'h0;
    end
    else if (stop_seen)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE: ;
        ST_RX:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_sync};
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
          end
          else if (byte_done)
          begin
            // Foreign addresses are left alone without acknowledge
            if (phase_reg == PH_DEV && shift_reg[7:1] != DEVICE_ADDRESS)
              state_reg <= ST_IDLE;
            else
              state_reg <= ST_ACK;
            if (phase_reg == PH_DEV)
              read_mode_reg <= shift_reg[0];
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            phase_reg <= (phase_reg == PH_DEV) ? PH_REG : PH_DATA;
            if (read_mode_reg)
            begin
              state_reg <= ST_TX;
              shift_reg <= bus.rdata;
            end
            else
            begin
              state_reg <= ST_RX;
              shift_reg <= 8'hFF;
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == 4'h7)
            begin
              state_reg <= ST_TX_ACK;
              shift_reg <= 8'hFF;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b1};
              bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise && sda_sync)
            state_reg <= ST_IDLE;
          else if (scl_fall)
          begin
            state_reg <= ST_TX;
            shift_reg <= bus.rdata;
            bit_cnt_reg <= 4'h0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register pointer and write strobe
  // ----------------------------------------------------------------
  // Pointer advances after each written byte and each acknowledged read byte so bursts walk the map
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      pointer_reg <= 8'h00;
      wr_en_reg <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else
    begin
      wr_en_reg <= byte_done && phase_reg == PH_DATA;
      if (byte_done && phase_reg == PH_DATA)
        wdata_reg <= shift_reg;
      if (byte_done && phase_reg == PH_REG)
        pointer_reg <= shift_reg;
      else if (wr_en_reg || (state_reg == ST_TX_ACK && scl_rise && !sda_sync))
        pointer_reg <= 8'(pointer_reg + 8'h01);
    end
  end

  assign bus.wr_en = wr_en_reg;
  assign bus.addr = pointer_reg;
  assign bus.wdata = wdata_reg;

endmodule : serial_config_port
`default_nettype wire

/* logic/output_clock_source_crossbar.sv */
// Overview of operation
// - Each output picks its own source independently
// - Codes: reference, bank taps /N, /2, /3, /4
// - Bank1 /2 aligns with /N when divisor%4==0
// - Bank1 /3 aligns with /N when divisor is 6
// - Bank2 /2 aligns with /N when divisor%4==0
// - Bank2 /4 aligns with /N when divisor%8==0
// - Select fields spread over three registers
// - Output runs only while its enable bit set
// - Each bank input picks oscillator or reference
`default_nettype none
module output_clock_source_crossbar
  import output_crossbar_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  output logic o_serial_data,
  output logic o_serial_data_oe,
  input wire logic i_reference_pin,
  input wire logic i_oscillator_pin,
  output logic o_output_a,
  output logic o_output_b,
  output logic o_output_c
);

  reg_access_if regs_if ();

  logic enable_a_reg, enable_b_reg, enable_c_reg;
  source_code_e select_a_reg, select_b_reg, select_c_reg;
  logic bank1_source_reg, bank2_source_reg;
  logic [6:0] bank1_divisor_reg, bank2_divisor_reg;
  logic ref_meta, ref_sync, ref_prev, osc_meta, osc_sync, osc_prev;
  logic ref_tick, osc_tick, bank1_tick, bank2_tick;
  logic bank1_n, bank1_half, bank1_third, bank2_n, bank2_half, bank2_quarter;
  logic [5:0] taps;
  logic [7:0] read_data;

  // Crosspoint: one mux per output, all codes decoded explicitly
  function automatic logic pick_source(input source_code_e sel, input logic ref_level,
                                       input logic [5:0] bank_taps);
    logic picked;
    picked = 1'b0;
    unique case (sel)
      SRC_REFERENCE: picked = ref_level;
      SRC_BANK1_N: picked = bank_taps[0];
      SRC_BANK1_HALF: picked = bank_taps[1];
      SRC_BANK1_THIRD: picked = bank_taps[2];
      SRC_BANK2_N: picked = bank_taps[3];
      SRC_BANK2_HALF: picked = bank_taps[4];
      SRC_BANK2_QUARTER: picked = bank_taps[5];
      SRC_RESERVED: picked = 1'b0;
    endcase
    return picked;
  endfunction : pick_source

  // ----------------------------------------------------------------
  // Serial configuration port
  // ----------------------------------------------------------------
  serial_config_port u_port (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_scl(i_serial_clock),
    .i_sda(i_serial_data),
    .o_sda(o_serial_data),
    .o_sda_oe(o_serial_data_oe),
    .bus(regs_if.port)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Enable bits; other bits of the enable register are not stored
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      enable_a_reg <= RST_ENABLE;
      enable_b_reg <= RST_ENABLE;
      enable_c_reg <= RST_ENABLE;
    end
    else if (regs_if.wr_en && regs_if.addr == ADDR_OUTPUT_ENABLE)
    begin
      enable_a_reg <= regs_if.wdata[ENABLE_BIT_A];
      enable_b_reg <= regs_if.wdata[ENABLE_BIT_B];
      enable_c_reg <= regs_if.wdata[ENABLE_BIT_C];
    end
  end

  // Select fields; filler bits are ignored rather than trusted
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      select_a_reg <= RST_SELECT;
      select_b_reg <= RST_SELECT;
      select_c_reg <= RST_SELECT;
    end
    else if (regs_if.wr_en)
    begin
      unique case (regs_if.addr)
        ADDR_SOURCE_SELECT_LO:
          select_b_reg <= source_code_e'({regs_if.wdata[1:0], select_b_reg[0]});
        ADDR_SOURCE_SELECT_MID:
        begin
          select_b_reg <= source_code_e'({select_b_reg[2:1], regs_if.wdata[7]});
          select_a_reg <= source_code_e'(regs_if.wdata[SEL_A_MSB:SEL_A_LSB]);
          select_c_reg <= source_code_e'({regs_if.wdata[0], select_c_reg[1:0]});
        end
        ADDR_SOURCE_SELECT_HI:
          select_c_reg <= source_code_e'({select_c_reg[2], regs_if.wdata[7:6]});
        default: ;
      endcase
    end
  end

  // Bank source and divisor; reserved addresses are simply ignored
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      bank1_source_reg <= RST_BANK_SOURCE;
      bank2_source_reg <= RST_BANK_SOURCE;
      bank1_divisor_reg <= RST_DIVISOR;
      bank2_divisor_reg <= RST_DIVISOR;
    end
    else if (regs_if.wr_en && regs_if.addr == ADDR_BANK1_CTRL)
    begin
      bank1_source_reg <= regs_if.wdata[BANK_SOURCE_BIT];
      bank1_divisor_reg <= regs_if.wdata[6:0];
    end
    else if (regs_if.wr_en && regs_if.addr == ADDR_BANK2_CTRL)
    begin
      bank2_source_reg <= regs_if.wdata[BANK_SOURCE_BIT];
      bank2_divisor_reg <= regs_if.wdata[6:0];
    end
  end

  // Read-back; filler bits of the select registers read as ones
  always_comb
  begin
    unique case (regs_if.addr)
      ADDR_OUTPUT_ENABLE:
        read_data = {2'h0, enable_c_reg, enable_a_reg, 1'b0, enable_b_reg, 2'h0};
      ADDR_BANK1_CTRL: read_data = {bank1_source_reg, bank1_divisor_reg};
      ADDR_SOURCE_SELECT_LO: read_data = {6'h3F, select_b_reg[2:1]};
      ADDR_SOURCE_SELECT_MID:
        read_data = {select_b_reg[0], 3'h7, select_a_reg, select_c_reg[2]};
      ADDR_SOURCE_SELECT_HI: read_data = {select_c_reg[1:0], 6'h3F};
      ADDR_BANK2_CTRL: read_data = {bank2_source_reg, bank2_divisor_reg};
      default: read_data = READ_UNMAPPED;
    endcase
  end
  assign regs_if.rdata = read_data;

  // ----------------------------------------------------------------
  // Source clocks and divider banks
  // ----------------------------------------------------------------
  // Source pins are sampled, so only rates well below i_clock survive
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      {ref_meta, ref_sync, ref_prev} <= 3'h0;
      {osc_meta, osc_sync, osc_prev} <= 3'h0;
    end
    else
    begin
      {ref_meta, ref_sync, ref_prev} <= {i_reference_pin, ref_meta, ref_sync};
      {osc_meta, osc_sync, osc_prev} <= {i_oscillator_pin, osc_meta, osc_sync};
    end
  end

  assign ref_tick = ref_sync & ~ref_prev;
  assign osc_tick = osc_sync & ~osc_prev;
  // Bank input: oscillator when source bit is set, reference otherwise
  assign bank1_tick = bank1_source_reg ? osc_tick : ref_tick;
  assign bank2_tick = bank2_source_reg ? osc_tick : ref_tick;

  divider_bank #(.FIXED_RATIO(BANK1_FIXED_RATIO)) u_bank1 (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_tick(bank1_tick),
    .i_divisor(bank1_divisor_reg),
    .o_div_n(bank1_n),
    .o_div_half(bank1_half),
    .o_div_fixed(bank1_third)
  );

  divider_bank #(.FIXED_RATIO(BANK2_FIXED_RATIO)) u_bank2 (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_tick(bank2_tick),
    .i_divisor(bank2_divisor_reg),
    .o_div_n(bank2_n),
    .o_div_half(bank2_half),
    .o_div_fixed(bank2_quarter)
  );

  assign taps = {bank2_quarter, bank2_half, bank2_n, bank1_third, bank1_half, bank1_n};

  // ----------------------------------------------------------------
  // Output crosspoint
  // ----------------------------------------------------------------
  // Registered so the pins carry no mux glitches
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_output_a <= 1'b0;
      o_output_b <= 1'b0;
      o_output_c <= 1'b0;
    end
    else
    begin
      o_output_a <= enable_a_reg & pick_source(select_a_reg, ref_sync, taps);
      o_output_b <= enable_b_reg & pick_source(select_b_reg, ref_sync, taps);
      o_output_c <= enable_c_reg & pick_source(select_c_reg, ref_sync, taps);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  output_a_ref_a: assert property (
    enable_a_reg && select_a_reg == SRC_REFERENCE |=> o_output_a == $past(ref_sync))
    else $error("output a does not follow reference");
  output_a_bank1_a: assert property (
    enable_a_reg && select_a_reg == SRC_BANK1_N |=> o_output_a == $past(bank1_n))
    else $error("output a does not follow bank1 divided tap");
  output_b_quarter_a: assert property (
    enable_b_reg && select_b_reg == SRC_BANK2_QUARTER |=> o_output_b == $past(bank2_quarter))
    else $error("output b does not follow bank2 quarter tap");
  disabled_low_a: assert property (
    !enable_a_reg [*2] |=> !o_output_a)
    else $error("disabled output a not low");
  reserved_low_a: assert property (
    select_c_reg == SRC_RESERVED |=> !o_output_c)
    else $error("reserved code output c not low");
  enable_write_a: assert property (
    regs_if.wr_en && regs_if.addr == ADDR_OUTPUT_ENABLE
    |=> enable_a_reg == $past(regs_if.wdata[ENABLE_BIT_A]) ##1 o_output_a == 1'b0 || enable_a_reg)
    else $error("enable write not applied");
  select_write_a: assert property (
    regs_if.wr_en && regs_if.addr == ADDR_SOURCE_SELECT_HI
    |=> select_c_reg[1:0] == $past(regs_if.wdata[7:6]) && $stable(select_a_reg))
    else $error("select write misplaced");
  bank_source_a: assert property (
    bank2_source_reg && !osc_tick && $stable(bank2_divisor_reg)
    |=> $stable(bank2_n) && $stable(bank2_half) && $stable(bank2_quarter))
    else $error("bank2 taps moved without oscillator tick");
  bank1_half_align_a: assert property (
    $rose(bank1_n) && bank1_divisor_reg[1:0] == 2'h0 && $stable(bank1_divisor_reg)
    |-> $rose(bank1_half))
    else $error("bank1 half tap not aligned");
  bank1_third_align_a: assert property (
    $rose(bank1_n) && bank1_divisor_reg == 7'h06 && $stable(bank1_divisor_reg)
    |-> $rose(bank1_third))
    else $error("bank1 third tap not aligned");
  bank2_half_align_a: assert property (
    $rose(bank2_n) && bank2_divisor_reg[1:0] == 2'h0 && $stable(bank2_divisor_reg)
    |-> $rose(bank2_half))
    else $error("bank2 half tap not aligned");
  bank2_quarter_align_a: assert property (
    $rose(bank2_n) && bank2_divisor_reg[2:0] == 3'h0 && $stable(bank2_divisor_reg)
    |-> $rose(bank2_quarter))
    else $error("bank2 quarter tap not aligned");

  bank1_third_used_c: cover property (
    enable_a_reg && select_a_reg == SRC_BANK1_THIRD ##1 $rose(o_output_a));
  bank2_from_osc_c: cover property (
    bank2_source_reg && enable_a_reg && select_a_reg == SRC_BANK2_N ##1 $rose(o_output_a));
  all_enabled_c: cover property (
    enable_a_reg && enable_b_reg && enable_c_reg && o_output_c);

endmodule : output_clock_source_crossbar
`default_nettype wire

/* dv/serial_host_model.sv */
`default_nettype none
// ----------------------------------------
// Two-wire master that configures the block
// ----------------------------------------
module serial_host_model
  import output_crossbar_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idles high on both lines
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // A third of a sent bit; slow so the pin synchronisers keep up
  task automatic q();
    repeat (10) @(posedge i_clock);
  endtask : q

  // One clock pulse, data line sampled while clock is high
  task automatic pulse(output logic bit_in);
    q();
    o_scl <= 1'b1;
    q();
    bit_in = i_sda;
    o_scl <= 1'b0;
  endtask : pulse

  // Also serves as repeated start, since clock is low on entry
  task automatic start();
    q();
    o_sda_low <= 1'b0;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_low <= 1'b1;
    q();
    o_scl <= 1'b0;
  endtask : start

  task automatic stop();
    q();
    o_sda_low <= 1'b1;
    q();
    o_scl <= 1'b1;
    q();
    o_sda_low <= 1'b0;
    q();
  endtask : stop

  // Data changes only mid-way through the low phase
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      q();
      o_sda_low <= ~b[i];
      pulse(s);
    end
    q();
    o_sda_low <= 1'b0;
    pulse(s);
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(s);
      b[i] = s;
    end
    q();
    o_sda_low <= ~last;
    pulse(s);
    q();
    o_sda_low <= 1'b0;
  endtask : recv

  // Fixed bits go out as ones; reserved places are never written
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    if (a inside {8'h09, 8'h0C, 8'h12, 8'h13, [8'h40:8'h42], [8'h44:8'h47]})
    begin
      d = d | (a == 8'h44 ? 8'hFC : a == 8'h45 ? 8'h70 : a == 8'h46 ? 8'h3F : 8'h00);
      start();
      send({DEVICE_ADDRESS, 1'b0});
      send(a);
      send(d);
      stop();
    end
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    start();
    send({DEVICE_ADDRESS, 1'b0});
    send(a);
    start();
    send({DEVICE_ADDRESS, 1'b1});
    recv(1'b1, d);
    stop();
  endtask : read_reg
endmodule : serial_host_model
`default_nettype wire

/* dv/test_output_clock_source_crossbar.sv */
`default_nettype none
module test_output_clock_source_crossbar;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref_pin = 1'b0;
  logic osc_pin = 1'b0;
  logic scl, sda_low, sdo, oe, sda;
  logic [2:0] outs;
  logic [2:0] prev = 3'h0;
  int cyc = 0;
  int n_fail = 0;
  int tests_run = 0;
  int mis = 0;
  int rises [3] = '{0, 0, 0};
  int seed = 32'h5d72_a0e2;
  logic [7:0] ra [7] = '{8'h09, 8'h44, 8'h45, 8'h46, 8'h0C, 8'h47, 8'h20};
  logic [7:0] rv [7] = '{8'h00, 8'hFC, 8'h70, 8'h3F, 8'h08, 8'h08, 8'h00};
  logic [2:0] tap [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
  int ratio [4] = '{2, 3, 2, 4};

  always #5 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda = ~(sda_low | oe);

  output_clock_source_crossbar u_output_clock_source_crossbar (
    .i_clock(clk), .i_reset(rst), .i_serial_clock(scl), .i_serial_data(sda),
    .o_serial_data(sdo), .o_serial_data_oe(oe), .i_reference_pin(ref_pin),
    .i_oscillator_pin(osc_pin), .o_output_a(outs[0]), .o_output_b(outs[1]),
    .o_output_c(outs[2]));
  serial_host_model u_serial_host_model (.i_clock(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));

  // ----------------------------------------
  // Pin clocks, edge counters, hang guard
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ref_pin <= (cyc % 8) < 4;
    osc_pin <= (cyc % 6) < 3;
    prev <= outs;
    mis <= mis + int'(outs[0] & ~prev[0] & ~(outs[1] & ~prev[1]));
    for (int j = 0; j < 3; j++)
      rises[j] <= rises[j] + int'(outs[j] & ~prev[j]);
    if (cyc == 90000)
    begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Bounded wait for a rising edge on one output
  task automatic rise(input int k);
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge clk);
      #1;
      if (outs[k] === 1'b1 && prev[k] === 1'b0)
        return;
    end
  endtask : rise

  task automatic period(input int k, output logic [15:0] p);
    int t0;
    rise(k);
    t0 = cyc;
    rise(k);
    p = 16'(cyc - t0);
  endtask : period

  // Split select fields; outputs a, b, c
  task automatic route(input logic [2:0] a, b, c, input logic [7:0] en);
    u_serial_host_model.write_reg(8'h44, {6'h00, b[2:1]});
    u_serial_host_model.write_reg(8'h45, {b[0], 3'h0, a, c[2]});
    u_serial_host_model.write_reg(8'h46, {c[1:0], 6'h00});
    u_serial_host_model.write_reg(8'h09, en);
  endtask : route

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [15:0] p;
    logic [6:0] n;
    int r, r0, m0, sp;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // Reset contents, unmapped read, quiet outputs
    for (int i = 0; i < 7; i++)
    begin
      u_serial_host_model.read_reg(ra[i], d);
      check({8'h00, d}, {8'h00, rv[i]});
    end
    check({12'h000, sdo, outs}, 16'h0000);
    $display("test reset done");
    // Each divided tap beside its bank's /N tap; reference on c in odd passes, c disabled in even ones
    for (int i = 0; i < 4; i++)
    begin
      r = $unsigned($random(seed)) % 40;
      n = (i == 1) ? 7'h06 : (i == 3) ? 7'(8 * (1 + r % 5)) : 7'(4 * (1 + r % 10));
      sp = (i < 2) ? 8 : 6;
      u_serial_host_model.write_reg(8'h0C, {1'b0, i < 2 ? n : 7'h08});
      u_serial_host_model.write_reg(8'h47, {1'b1, i < 2 ? 7'h08 : n});
      route(i < 2 ? 3'h1 : 3'h4, tap[i], 3'h0, (i % 2) ? 8'h34 : 8'h14);
      period(0, p);
      r0 = rises[2];
      m0 = mis;
      period(0, p);
      check(p, 16'(sp * n));
      period(1, p);
      check(p, 16'(sp * ratio[i]));
      check(16'(mis - m0), 16'h0000);
      if (i % 2)
      begin
        period(2, p);
        check(p, 16'h0008);
      end
      else
        check(16'(rises[2] - r0), 16'h0000);
      $display("test tap %0d done", i);
    end
    // Output a disabled must stay low while b follows the reference
    route(3'h0, 3'h0, 3'h0, 8'h24);
    period(1, p);
    r0 = rises[0];
    period(1, p);
    check(p, 16'h0008);
    check(16'(rises[0] - r0), 16'h0000);
    u_serial_host_model.read_reg(8'h45, d);
    check({8'h00, d}, 16'h0070);
    $display("test disable done");
    give_verdict();
  end
endmodule : test_output_clock_source_crossbar
`default_nettype wire
